/* File: duty_meter.sv */
// PWM input duty-cycle meter with selectable polarity
`timescale 1ns/1ns
`include "led_zone_defines.svh"
module duty_meter
  import led_zone_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pwm_in,
  input wire logic active_low,
  output logic [7:0] duty_q
);
  logic prev_q;
  logic prev_d;
  logic [15:0] period_q;
  logic [15:0] period_d;
  logic [15:0] active_q;
  logic [15:0] active_d;
  logic [7:0] duty_d;
  logic act;
  logic [23:0] ratio;

  always_comb begin
    act = pwm_in ^ active_low;
    prev_d = pwm_in;
    period_d = period_q;
    active_d = active_q;
    duty_d = duty_q;
    ratio = 24'((active_q * 24'(`DUTY_FULL)) / 24'(period_q));
    if (pwm_in && !prev_q) begin
      duty_d = (period_q == 16'h0000) ? duty_q : ratio[7:0];
      period_d = 16'h0001;
      active_d = {15'h0000, act};
    end else if (period_q == `PWM_CNT_MAX) begin
      duty_d = act ? `DUTY_FULL : 8'h00;
    end else begin
      period_d = period_q + 16'h0001;
      active_d = active_q + {15'h0000, act};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b0;
      period_q <= 16'h0000;
      active_q <= 16'h0000;
      duty_q <= 8'h00;
    end else begin
      prev_q <= prev_d;
      period_q <= period_d;
      active_q <= active_d;
      duty_q <= duty_d;
    end
  end
endmodule : duty_meter

/* File: led_brightness_als_zone_control.sv */
// LED current targets per bank with ramping, PWM scaling and light zones
`timescale 1ns/1ns
`include "led_zone_defines.svh"
// Contract
// - Each bank picks exponential or linear code mapping on its own.
// - Exponential current follows the 0.862 power law times duty.
// - Linear current is full scale times code over 255 times duty.
// - Eight startup and eight shutdown times, shared by all banks.
// - Startup ramps to set point; shutdown ramps down to zero.
// - Eight ramp-up and eight ramp-down run-time times, shared.
// - Register mode follows the bank's 8-bit brightness code.
// - With PWM on, current scales linearly with duty cycle.
// - Active-low polarity uses the low-time fraction as duty.
// - Five light zones, three independent sets of zone targets.
// - Four upper and four lower 8-bit zone boundaries.
// - Zone rises only when level exceeds the upper boundary.
// - Zone falls only when level drops below the lower boundary.
// - Set one serves bank one only; sets two, three any other bank.
// - Zone targets are 8-bit codes mapped by the bank's mode.
// - Each zone can enable PWM scaling of its target.
// - Sensor select low picks analog, high picks PWM sensor.
// - Analog mode offers 128 gain resistor codes, one high-Z.
// - Converter is 8 bits, code 0xFF meaning 2V.
// - Converter result refreshes every 140us while enabled.
// - Zone starts at zero when the light function starts.
// - PWM sensor mode forces the gain resistor to high-Z.
module led_brightness_als_zone_control
  import led_zone_pkg::*;
#(
  parameter int unsigned ADC_PERIOD_CYC = `ADC_PERIOD_NS / `CLK_PERIOD_NS
)(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pwm_in,
  input wire logic pwm_active_low,
  input wire ramp_cfg_s ramp_cfg,
  input wire bank_cfg_s [`NUM_BANKS-1:0] bank_cfg,
  input wire als_cfg_s als_cfg,
  input wire bounds_t zone_bound_high,
  input wire bounds_t zone_bound_low,
  input wire zone_targets_t zone_target_set_one,
  input wire zone_targets_t zone_target_set_two,
  input wire zone_targets_t zone_target_set_three,
  input wire logic [`NUM_ZONES-1:0] zone_pwm_en,
  input wire logic [7:0] adc_sample_in,
  output logic adc_convert,
  output logic [7:0] adc_result_q,
  output logic [6:0] gain_sel_q,
  output logic [2:0] zone_q,
  output logic [7:0] pwm_duty,
  output logic [`NUM_BANKS-1:0][7:0] ramp_code_q,
  output logic [`NUM_BANKS-1:0][15:0] led_current_q
);
  logic [15:0] adc_tmr_q;
  logic [15:0] adc_tmr_d;
  logic [7:0] adc_result_d;
  logic [2:0] zone_d;
  logic [6:0] gain_sel_d;
  logic als_on_q;
  logic als_on_d;
  logic tick;
  logic [`NUM_BOUNDS-1:0] above_high;
  logic [`NUM_BOUNDS-1:0] below_low;

  duty_meter u_duty (
    .ref_clk(ref_clk),
    .rst(rst),
    .pwm_in(pwm_in),
    .active_low(pwm_active_low),
    .duty_q(pwm_duty)
  );

  function automatic logic [15:0] exp_frac(input logic [7:0] code);
    logic [16:0] prod;
    logic [8:0] att;
    logic [16:0] mant;
    prod = 17'(({9'h000, (`CODE_FULL - code)}) * 17'(`EXP_SLOPE_Q8));
    att = prod[16:8];
    mant = 17'h10000 - 17'({8'h00, att[7:0]} * 17'(`EXP_HALF_Q8));
    mant = mant >> att[8];
    exp_frac = (mant[16]) ? 16'hFFFF : mant[15:0];
  endfunction : exp_frac

  function automatic logic [15:0] step_cyc(input logic [2:0] sel);
    step_cyc = 16'(16'(`RAMP_STEP_CYC) << sel);
  endfunction : step_cyc

  assign tick = als_cfg.enable && (adc_tmr_q == 16'(ADC_PERIOD_CYC - 1));
  assign adc_convert = tick;

  for (genvar i = 0; i < `NUM_BOUNDS; i++) begin : g_bound
    assign above_high[i] = adc_sample_in > zone_bound_high[i];
    assign below_low[i] = adc_sample_in < zone_bound_low[i];
  end

  always_comb begin
    als_on_d = als_cfg.enable;
    adc_tmr_d = adc_tmr_q;
    adc_result_d = adc_result_q;
    zone_d = zone_q;
    gain_sel_d = als_cfg.pwm_sensor ? `GAIN_HIGH_Z :
                 als_cfg.gain_sel;
    if (!als_cfg.enable) begin
      adc_tmr_d = 16'h0000;
    end else if (!als_on_q) begin
      adc_tmr_d = 16'h0000;
      zone_d = `ZONE_BOTTOM;
    end else if (tick) begin
      adc_tmr_d = 16'h0000;
      adc_result_d = adc_sample_in;
      if (zone_q != `ZONE_TOP && above_high[zone_q[1:0]]) begin
        zone_d = zone_q + 3'h1;
      end else if (zone_q != `ZONE_BOTTOM &&
          below_low[2'(zone_q - 3'h1)]) begin
        zone_d = zone_q - 3'h1;
      end
    end else begin
      adc_tmr_d = adc_tmr_q + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      als_on_q <= 1'b0;
      adc_tmr_q <= 16'h0000;
      adc_result_q <= 8'h00;
      zone_q <= `ZONE_BOTTOM;
      gain_sel_q <= `GAIN_HIGH_Z;
    end else begin
      als_on_q <= als_on_d;
      adc_tmr_q <= adc_tmr_d;
      adc_result_q <= adc_result_d;
      zone_q <= zone_d;
      gain_sel_q <= gain_sel_d;
    end
  end

  for (genvar b = 0; b < `NUM_BANKS; b++) begin : g_bank
    ramp_st_e st_q;
    ramp_st_e st_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [7:0] code_d;
    logic [15:0] cur_d;
    logic [7:0] tgt;
    logic [7:0] zone_tgt;
    logic [2:0] sel;
    logic use_pwm;
    logic [15:0] frac;
    logic [23:0] scaled;
    logic [20:0] fs_prod;
    logic step;

    always_comb begin
      if (b == 0) begin
        zone_tgt = zone_target_set_one[zone_q];
      end else if (bank_cfg[b].set_three) begin
        zone_tgt = zone_target_set_three[zone_q];
      end else begin
        zone_tgt = zone_target_set_two[zone_q];
      end
      if (bank_cfg[b].zone_ctrl && als_cfg.enable) begin
        tgt = zone_tgt;
        use_pwm = zone_pwm_en[zone_q];
      end else begin
        tgt = bank_cfg[b].code;
        use_pwm = bank_cfg[b].pwm_en;
      end
    end

    always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      code_d = ramp_code_q[b];
      sel = ramp_cfg.startup;
      case (st_q)
        RAMP_IDLE: begin
          code_d = `CODE_ZERO;
          cnt_d = 16'h0000;
          if (bank_cfg[b].enable) begin
            st_d = RAMP_START;
          end
        end
        RAMP_START: begin
          sel = ramp_cfg.startup;
          if (!bank_cfg[b].enable) begin
            st_d = RAMP_STOP;
          end else if (ramp_code_q[b] == tgt) begin
            st_d = RAMP_RUN;
          end
        end
        RAMP_RUN: begin
          sel = (tgt > ramp_code_q[b]) ? ramp_cfg.ramp_up :
                ramp_cfg.ramp_down;
          if (!bank_cfg[b].enable) begin
            st_d = RAMP_STOP;
          end
        end
        RAMP_STOP: begin
          sel = ramp_cfg.shutdown;
          if (bank_cfg[b].enable) begin
            st_d = RAMP_START;
          end else if (ramp_code_q[b] == `CODE_ZERO) begin
            st_d = RAMP_IDLE;
          end
        end
        default: begin
          st_d = RAMP_IDLE;
        end
      endcase
      step = (cnt_q >= step_cyc(sel) - 16'h0001);
      if (st_q != RAMP_IDLE) begin
        if (st_q == RAMP_STOP || !bank_cfg[b].enable) begin
          if (ramp_code_q[b] == `CODE_ZERO) begin
            cnt_d = 16'h0000;
          end else if (step) begin
            cnt_d = 16'h0000;
            code_d = ramp_code_q[b] - 8'h01;
          end else begin
            cnt_d = cnt_q + 16'h0001;
          end
        end else if (ramp_code_q[b] == tgt) begin
          cnt_d = 16'h0000;
        end else if (step) begin
          cnt_d = 16'h0000;
          code_d = (tgt > ramp_code_q[b]) ? ramp_code_q[b] + 8'h01 :
                   ramp_code_q[b] - 8'h01;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
    end

    always_comb begin
      if (bank_cfg[b].linear) begin
        frac = 16'({9'h000, ramp_code_q[b]} * `LIN_SCALE);
      end else begin
        frac = exp_frac(ramp_code_q[b]);
      end
      if (use_pwm) begin
        scaled = 24'((frac * 24'(pwm_duty)) / 24'(`DUTY_FULL));
      end else begin
        scaled = {8'h00, frac};
      end
      fs_prod = 21'(scaled[15:0] *
                21'({1'b0, bank_cfg[b].full_scale_current} + 6'h01));
      cur_d = (ramp_code_q[b] == `CODE_ZERO) ? 16'h0000 :
              fs_prod[20:5];
    end

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        st_q <= RAMP_IDLE;
        cnt_q <= 16'h0000;
        ramp_code_q[b] <= `CODE_ZERO;
        led_current_q[b] <= 16'h0000;
      end else begin
        st_q <= st_d;
        cnt_q <= cnt_d;
        ramp_code_q[b] <= code_d;
        led_current_q[b] <= cur_d;
      end
    end
  end
endmodule : led_brightness_als_zone_control

/* File: led_zone_defines.svh */
// Constants for the LED brightness and ambient-light zone block
`ifndef LED_ZONE_DEFINES_SVH
`define LED_ZONE_DEFINES_SVH
`define NUM_BANKS 6
`define NUM_ZONES 5
`define NUM_BOUNDS 4
`define CLK_PERIOD_NS 10
`define ADC_PERIOD_NS 140000
`define RAMP_STEP_NS 1000
`define RAMP_STEP_CYC (`RAMP_STEP_NS / `CLK_PERIOD_NS)
`define CODE_ZERO 8'h00
`define CODE_FULL 8'hFF
`define LIN_SCALE 17'h00101
`define EXP_SLOPE_Q8 9'h1D0
`define EXP_HALF_Q8 9'h080
`define GAIN_HIGH_Z 7'h00
`define PWM_CNT_MAX 16'hFFFF
`define DUTY_FULL 8'hFF
`define ZONE_BOTTOM 3'h0
`define ZONE_TOP 3'h4
`endif

/* File: led_zone_monitor.sv */
// Port checker for the LED brightness and light zone block
`timescale 1ns/1ns
`include "led_zone_defines.svh"
module led_zone_monitor
  import led_zone_pkg::*;
#(
  parameter int unsigned ADC_PERIOD_CYC = 14000
)(
  input wire logic ref_clk,
  input wire logic rst,
  input wire bank_cfg_s [`NUM_BANKS-1:0] bank_cfg,
  input wire als_cfg_s als_cfg,
  input wire bounds_t zone_bound_high,
  input wire bounds_t zone_bound_low,
  input wire logic [7:0] adc_sample_in,
  input wire logic adc_convert,
  input wire logic [7:0] adc_result_q,
  input wire logic [6:0] gain_sel_q,
  input wire logic [2:0] zone_q,
  input wire logic [`NUM_BANKS-1:0][7:0] ramp_code_q,
  input wire logic [`NUM_BANKS-1:0][15:0] led_current_q
);
  logic [15:0] gap_q;
  logic [15:0] gap_d;
  logic seen_q;
  logic seen_d;
  always_comb begin
    gap_d = adc_convert ? 16'h0000 : gap_q + 16'h0001;
    seen_d = als_cfg.enable && (seen_q || adc_convert);
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b0;
    end else begin
      gap_q <= gap_d;
      seen_q <= seen_d;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_up;
    adc_convert && zone_q < `ZONE_TOP
      && adc_sample_in > zone_bound_high[zone_q[1:0]];
  endsequence
  sequence s_down;
    adc_convert && zone_q != `ZONE_BOTTOM
      && adc_sample_in < zone_bound_low[zone_q[1:0] - 2'h1];
  endsequence
  a_gain_hiz: assert property (
    als_cfg.pwm_sensor |=> gain_sel_q == `GAIN_HIGH_Z) else $error("gain");
  a_gain_follow: assert property (
    !als_cfg.pwm_sensor |=> gain_sel_q == $past(als_cfg.gain_sel))
    else $error("gain sel");
  a_adc_store: assert property (
    adc_convert |=> adc_result_q == $past(adc_sample_in)) else $error("adc");
  a_tick_period: assert property (
    adc_convert && seen_q |-> gap_q == ADC_PERIOD_CYC - 1) else $error("tick");
  a_zone_rise: assert property (
    s_up |=> zone_q == $past(zone_q) + 3'h1) else $error("zone up");
  a_zone_fall: assert property (
    s_down |=> zone_q == $past(zone_q) - 3'h1) else $error("zone down");
  a_zone_init: assert property (
    $rose(als_cfg.enable) |=> zone_q == `ZONE_BOTTOM) else $error("zone init");
  a_ramp_step: assert property (
    $changed(ramp_code_q[0]) |->
      ramp_code_q[0] - $past(ramp_code_q[0]) inside {8'h01, 8'hFF})
    else $error("ramp step");
  a_off_zero: assert property (
    ramp_code_q[0] == `CODE_ZERO |=> led_current_q[0] == 16'h0000)
    else $error("off current");
  a_idle_zero: assert property (
    !bank_cfg[0].enable && ramp_code_q[0] == `CODE_ZERO
      |=> ramp_code_q[0] == `CODE_ZERO) else $error("idle code");
endmodule : led_zone_monitor

bind led_brightness_als_zone_control led_zone_monitor #(
  .ADC_PERIOD_CYC(ADC_PERIOD_CYC)
) i_mon (
  .ref_clk(ref_clk), .rst(rst), .bank_cfg(bank_cfg), .als_cfg(als_cfg),
  .zone_bound_high(zone_bound_high), .zone_bound_low(zone_bound_low),
  .adc_sample_in(adc_sample_in), .adc_convert(adc_convert),
  .adc_result_q(adc_result_q), .gain_sel_q(gain_sel_q), .zone_q(zone_q),
  .ramp_code_q(ramp_code_q), .led_current_q(led_current_q)
);

/* File: led_zone_partner.sv */
// Light sensor and PWM source model
`timescale 1ns/1ns
module led_zone_partner (
  input wire logic ref_clk,
  input wire logic [7:0] light_level,
  input wire logic [15:0] pwm_period,
  input wire logic [15:0] pwm_high,
  output logic [7:0] adc_sample_in,
  output logic pwm_in
);
  logic [15:0] cnt_q = 16'h0000;
  always @(posedge ref_clk) begin
    cnt_q <= (cnt_q >= pwm_period - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
    pwm_in <= #1 (cnt_q < pwm_high);
  end
  assign adc_sample_in = light_level;
endmodule : led_zone_partner

/* File: led_zone_pkg.sv */
// Types shared by the LED brightness and ambient-light zone block
package led_zone_pkg;
  typedef struct packed {
    logic enable;
    logic linear;
    logic pwm_en;
    logic zone_ctrl;
    logic set_three;
    logic [7:0] code;
    logic [4:0] full_scale_current;
  } bank_cfg_s;

  typedef struct packed {
    logic [2:0] startup;
    logic [2:0] shutdown;
    logic [2:0] ramp_up;
    logic [2:0] ramp_down;
  } ramp_cfg_s;

  typedef struct packed {
    logic enable;
    logic pwm_sensor;
    logic [6:0] gain_sel;
  } als_cfg_s;

  typedef logic [4:0][7:0] zone_targets_t;
  typedef logic [3:0][7:0] bounds_t;

  typedef enum logic [1:0] {
    RAMP_IDLE = 2'b00,
    RAMP_START = 2'b01,
    RAMP_RUN = 2'b11,
    RAMP_STOP = 2'b10
  } ramp_st_e;
endpackage : led_zone_pkg

/* File: test_led_brightness_als_zone_control.sv */
// Testbench for the LED brightness and light zone block
`timescale 1ns/1ns
`include "led_zone_defines.svh"
module test_led_brightness_als_zone_control;
  import led_zone_pkg::*;
  localparam int unsigned TICK = 20;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic pwm_in;
  logic pwm_active_low = 1'b0;
  ramp_cfg_s ramp_cfg = '0;
  bank_cfg_s [`NUM_BANKS-1:0] bank_cfg = '0;
  als_cfg_s als_cfg = '0;
  bounds_t bnd_hi = '0;
  bounds_t bnd_lo = '0;
  zone_targets_t set1 = '0;
  zone_targets_t set2 = '0;
  zone_targets_t set3 = '0;
  logic [4:0] zpwm = 5'h00;
  logic [7:0] level = 8'h00;
  logic [15:0] per = 16'h03E8;
  logic [15:0] hi = 16'h0100;
  logic [7:0] adc_sample_in;
  logic adc_convert;
  logic [7:0] adc_result_q;
  logic [6:0] gain_sel_q;
  logic [2:0] zone_q;
  logic [7:0] pwm_duty;
  logic [`NUM_BANKS-1:0][7:0] ramp_code_q;
  logic [`NUM_BANKS-1:0][15:0] led_current_q;
  logic [2:0] exp_zone = 3'h0;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;

  led_brightness_als_zone_control #(.ADC_PERIOD_CYC(TICK)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .pwm_in(pwm_in),
    .pwm_active_low(pwm_active_low), .ramp_cfg(ramp_cfg),
    .bank_cfg(bank_cfg), .als_cfg(als_cfg), .zone_bound_high(bnd_hi),
    .zone_bound_low(bnd_lo), .zone_target_set_one(set1),
    .zone_target_set_two(set2), .zone_target_set_three(set3),
    .zone_pwm_en(zpwm), .adc_sample_in(adc_sample_in),
    .adc_convert(adc_convert), .adc_result_q(adc_result_q),
    .gain_sel_q(gain_sel_q), .zone_q(zone_q), .pwm_duty(pwm_duty),
    .ramp_code_q(ramp_code_q), .led_current_q(led_current_q)
  );
  led_zone_partner i_partner (
    .ref_clk(ref_clk), .light_level(level), .pwm_period(per),
    .pwm_high(hi), .adc_sample_in(adc_sample_in), .pwm_in(pwm_in)
  );

  always #5 ref_clk = ~ref_clk;

  task automatic end_sim();
    if (mismatches == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      end_sim();
    end
  end

  function automatic logic [2:0] zone_next(logic [2:0] z, logic [7:0] s);
    if (z < 3'h4 && s > bnd_hi[z[1:0]]) return z + 3'h1;
    if (z > 3'h0 && s < bnd_lo[z[1:0] - 2'h1]) return z - 3'h1;
    return z;
  endfunction : zone_next

  function automatic logic [15:0] lin_cur(logic [7:0] c, logic [4:0] fs,
                                          int d);
    int f;
    f = (c * 257 * d) / 255;
    return 16'((f * (fs + 1)) / 32);
  endfunction : lin_cur

  // Zone model, stepped at each sampling instant
  always @(negedge ref_clk) begin
    if (!als_cfg.enable) exp_zone <= 3'h0;
    else if (adc_convert) exp_zone <= zone_next(exp_zone, adc_sample_in);
  end

  task automatic step(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wait_code(int b, logic [7:0] c);
    int n = 0;
    while (ramp_code_q[b] !== c && n < 20000) begin
      step(1);
      n++;
    end
  endtask : wait_code

  initial begin
    int n0;
    logic [7:0] c;
    logic [2:0] sel;
    int d;
    logic [4:0] fs0;
    void'($urandom(32'h1A20));
    for (int i = 0; i < 4; i++) begin
      bnd_hi[i] = 8'h38 + 8'(i * 48);
      bnd_lo[i] = 8'h28 + 8'(i * 48);
    end
    for (int b = 1; b < 6; b++) bank_cfg[b] = bank_cfg_s'(18'($urandom));
    set1 = 40'({$urandom, $urandom}) & {5{8'h1F}};
    set2 = 40'({$urandom, $urandom}) & {5{8'h1F}};
    set3 = 40'({$urandom, $urandom}) & {5{8'h1F}};
    zpwm = 5'($urandom);
    repeat (10) @(posedge ref_clk);
    check("zone", 0, zone_q);
    #1 rst = 1'b0;
    sel = 3'($urandom_range(2));
    c = 8'($urandom_range(6, 3));
    ramp_cfg = {sel, 3'($urandom_range(2)), 6'h00};
    bank_cfg[0] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, c, 5'h1F};
    wait_code(0, 8'h01);
    n0 = cycles;
    wait_code(0, 8'h02);
    check("step", 16'(100 << sel), 16'(cycles - n0));
    wait_code(0, c);
    step(2);
    check("lin", 16'(c * 257), led_current_q[0]);
    bank_cfg[0].linear = 1'b0;
    step(2);
    check("exp", 1, 16'(led_current_q[0] > 16'(c * 257)));
    bank_cfg[0].enable = 1'b0;
    wait_code(0, 8'h00);
    step(2);
    check("off", 0, led_current_q[0]);
    per = 16'($urandom_range(1500, 1000));
    hi = 16'($urandom_range(900, 10));
    for (int p = 0; p < 2; p++) begin
      pwm_active_low = p[0];
      step(3 * per);
      check("duty", 16'(((p ? per - hi : hi) * 255) / per), pwm_duty);
    end
    d = ((per - hi) * 255) / per;
    fs0 = 5'($urandom);
    ramp_cfg = '0;
    bank_cfg[0] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00, fs0};
    bank_cfg[1].enable = 1'b1;
    bank_cfg[1].zone_ctrl = 1'b1;
    als_cfg.enable = 1'b1;
    for (int i = 0; i < 14; i++) begin
      level = i == 4 ? bnd_lo[2] : 8'($urandom);
      if (i < 4) level = bnd_hi[i] - 8'(i % 2);
      als_cfg.pwm_sensor = 1'($urandom);
      als_cfg.gain_sel = 7'($urandom);
      step(6 * TICK);
      check("zone", exp_zone, zone_q);
      check("adc", level, adc_result_q);
      n0 = als_cfg.pwm_sensor ? 0 : als_cfg.gain_sel;
      check("gain", n0, gain_sel_q);
      c = bank_cfg[1].set_three ? set3[exp_zone] : set2[exp_zone];
      wait_code(1, c);
      check("set", c, ramp_code_q[1]);
      wait_code(0, set1[exp_zone]);
      check("set1", set1[exp_zone], ramp_code_q[0]);
      n0 = zpwm[exp_zone] ? d : 255;
      step(2);
      check("cur", lin_cur(set1[exp_zone], fs0, n0), led_current_q[0]);
    end
    end_sim();
  end
endmodule : test_led_brightness_als_zone_control
